// file: hdl/rsc_pkg.sv
package rsc_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] RSC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] RSC_ADDR_STATUS = 8'h04;
    localparam logic [7:0] RSC_ADDR_STRAP = 8'h08;
    // Control register fields
    localparam int RSC_CTRL_SEL_BIT = 0;
    localparam int RSC_CTRL_SRC_BIT = 1;
    localparam int RSC_CTRL_MAN_BIT = 2;
    localparam int RSC_CTRL_W = 3;
    localparam logic [RSC_CTRL_W-1:0] RSC_CTRL_RST = 3'h0;
    // Status register layout is rsc_status_t in the low bits
    localparam int RSC_STATUS_W = 6;
    // Strap register carries only the low 13 bits of each strap frequency
    localparam int RSC_KHZ_W = 19;
    // AXI responses
    localparam logic [1:0] RSC_RESP_OKAY = 2'h0;
    localparam logic [1:0] RSC_RESP_SLVERR = 2'h2;
    // Qualification timing, counted in phase-detector cycles
    localparam int RSC_PFD_KHZ = 66670;
    localparam int RSC_FAIL_HOLD_PFD = 128;
    localparam int RSC_HOLD_W = $clog2(RSC_FAIL_HOLD_PFD);
    localparam logic [RSC_HOLD_W-1:0] RSC_HOLD_LAST = 7'h7F;
    localparam int RSC_PH_WIN = 8;
    localparam int RSC_PH_BAD_MAX = 5;
    localparam logic [RSC_PH_WIN-1:0] RSC_PH_CLEAN = 8'h00;
    // Frequency deviation thresholds in tenths of a percent
    localparam logic [7:0] RSC_FQ_QUAL_TENTHS = 8'h18;
    localparam logic [7:0] RSC_FQ_DISQ_TENTHS = 8'h50;
    // Amplitude fault filter, least time rounded up to clock cycles
    localparam int RSC_CLK_MHZ = 100;
    localparam int RSC_AMP_MIN_NS = 50;
    localparam int RSC_AMP_MAX_NS = 300;
    localparam int RSC_AMP_CYC = (RSC_AMP_MIN_NS * RSC_CLK_MHZ + 999) / 1000;
    localparam logic [2:0] RSC_AMP_CYC_V = 3'(RSC_AMP_CYC);
    // Four-level strap encodings and their frequencies in kHz
    localparam logic [1:0] RSC_STRAP_GND = 2'h0;
    localparam logic [1:0] RSC_STRAP_VCC = 2'h1;
    localparam logic [1:0] RSC_STRAP_OPEN = 2'h2;
    localparam logic [1:0] RSC_STRAP_RES = 2'h3;
    localparam logic [RSC_KHZ_W-1:0] RSC_F_GND = 19'h1046E;
    localparam logic [RSC_KHZ_W-1:0] RSC_F_VCC = 19'h208D2;
    localparam logic [RSC_KHZ_W-1:0] RSC_F_OPEN = 19'h411AE;
    localparam logic [RSC_KHZ_W-1:0] RSC_F_RES = 19'h51612;

    typedef struct packed {
        logic amp_ok;
        logic phase_err;
        logic [7:0] freq_dev;
    } rsc_ref_in_t;

    typedef struct packed {
        logic holdover;
        logic busy_n;
        logic lock_n;
        logic active;
        logic [1:0] fail_n;
    } rsc_status_t;

    typedef enum logic [1:0] {RSC_RUN, RSC_SWITCH, RSC_HOLD} rsc_state_t;
endpackage

// file: hdl/rsc_switch_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// R01 - Auto: active fails, go to valid other
// R02 - Switching-activity low until phase realigned
// R03 - Lock stays reported during normal switchover
// R04 - Failure flag held, re-evaluated every 128 cycles
// R05 - Target drops mid-switch: holdover, then resume
// R06 - Stay on secondary while it stays valid
// R07 - Choice transition switches if different and valid
// R08 - Other side holds choice level two cycles
// R09 - Other side checks flag, retoggles if needed
// R10 - Both references invalid: enter holdover, keep monitoring
// R11 - Leave holdover to choice or single valid
// R12 - Manual: active flag follows the choice input
// R13 - Manual switch ignores validity, flags still update
// R14 - Failure flag combines amplitude, frequency, phase
// R15 - Idle reference judged by amplitude, frequency only
// R16 - Amplitude fault reported within 50 to 300ns
// R17 - Phase disqualify on more than 5 of 8
// R18 - Phase qualify after 8 clean cycles
// R19 - Phase check only on driving reference
// R20 - Frequency hysteresis between 2.4% and 8%
// R21 - Input divider strap selects input frequency
// R22 - Group A strap selects group A frequency
// R23 - Holdover: active flag low, activity high
// R24 - Bypass strap forces manual behaviour
// R25 - Reset: flags high, active 0, indicators high
// R26 - All qualification timed by phase-detector cycles; the amplitude filter counts mclk cycles instead
// R27 - Choice and mode inputs synchronised, edges compared
module rsc_switch_ctrl
    import rsc_pkg::*;
#(
    parameter int REALIGN_PFD = 64,
    parameter int ADDR_W = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic pfd_tick,
    input wire rsc_ref_in_t [1:0] ref_in,
    input wire logic ref_choice_pin,
    input wire logic switch_policy_pin,
    input wire logic bypass_pin,
    input wire logic [1:0] input_div_strap,
    input wire logic [1:0] group_a_div_strap,
    output logic ref_a_fail_n,
    output logic ref_b_fail_n,
    output logic active_ref,
    output logic busy_n,
    output logic lock_n,
    output logic [RSC_KHZ_W-1:0] ref_freq_khz,
    output logic [RSC_KHZ_W-1:0] group_a_freq_khz,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int RA_W = $clog2(REALIGN_PFD + 1);
    localparam logic [RA_W-1:0] REALIGN_LAST = RA_W'(REALIGN_PFD - 1);

    function automatic logic [RSC_KHZ_W-1:0] strap_khz(input logic [1:0] s);
        unique case (s)
            RSC_STRAP_GND: strap_khz = RSC_F_GND;
            RSC_STRAP_VCC: strap_khz = RSC_F_VCC;
            RSC_STRAP_OPEN: strap_khz = RSC_F_OPEN;
            RSC_STRAP_RES: strap_khz = RSC_F_RES;
        endcase
    endfunction

    // Pin synchronisers and choice edge detection
    logic [2:0] pin_s1_q, pin_s2_q;
    logic choice_prev_q;
    logic [RSC_CTRL_W-1:0] ctrl_q;
    wire choice = ctrl_q[RSC_CTRL_SRC_BIT] ? ctrl_q[RSC_CTRL_SEL_BIT] : pin_s2_q[0];
    wire bypass = pin_s2_q[2];
    wire manual = pin_s2_q[1] | bypass | ctrl_q[RSC_CTRL_MAN_BIT]; // [R24]
    wire choice_edge = choice != choice_prev_q; // [R27]
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            choice_prev_q <= 1'b0;
        end else if (clk_en) begin
            pin_s1_q <= {bypass_pin, switch_policy_pin, ref_choice_pin}; // [R27]
            pin_s2_q <= pin_s1_q;
            choice_prev_q <= choice;
        end
    end

    // Per-reference qualification
    rsc_state_t st_q, st_d;
    logic act_q, act_d;
    logic [1:0] fail_n_q, freq_ok_q, phase_ok_q, amp_good;
    logic [RSC_PH_WIN-1:0] ph_hist_q [2];
    logic [RSC_HOLD_W-1:0] hold_cnt_q [2];
    logic [3:0] ph_bad [2];
    wire driving_valid = st_q != RSC_HOLD;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ref
            logic [2:0] amp_cnt_q;
            wire drives = driving_valid && act_q == 1'(g) && !bypass; // [R19]
            wire [7:0] dev = ref_in[g].freq_dev;
            wire raw_ok = amp_good[g] & freq_ok_q[g] & (drives ? phase_ok_q[g] : 1'b1); // [R14] [R15]
            wire hold_done = pfd_tick && hold_cnt_q[g] == RSC_HOLD_LAST;
            assign amp_good[g] = amp_cnt_q != RSC_AMP_CYC_V;
            assign ph_bad[g] = 4'($countones(ph_hist_q[g]));
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    amp_cnt_q <= 3'h0;
                    freq_ok_q[g] <= 1'b0;
                    phase_ok_q[g] <= 1'b1;
                    ph_hist_q[g] <= RSC_PH_CLEAN;
                    fail_n_q[g] <= 1'b1; // [R25]
                    hold_cnt_q[g] <= '0;
                end else if (clk_en) begin
                    // Short faults below the filter length are glitches, not failures
                    if (ref_in[g].amp_ok) begin
                        amp_cnt_q <= 3'h0;
                    end else if (amp_good[g]) begin
                        amp_cnt_q <= amp_cnt_q + 3'h1; // [R16]
                    end
                    if (freq_ok_q[g] && dev > RSC_FQ_DISQ_TENTHS) begin
                        freq_ok_q[g] <= 1'b0; // [R20]
                    end else if (!freq_ok_q[g] && dev <= RSC_FQ_QUAL_TENTHS) begin
                        freq_ok_q[g] <= 1'b1; // [R20]
                    end
                    if (pfd_tick && drives) begin // [R26]
                        ph_hist_q[g] <= {ph_hist_q[g][RSC_PH_WIN-2:0], ref_in[g].phase_err};
                        if (ph_bad[g] > 4'(RSC_PH_BAD_MAX)) begin
                            phase_ok_q[g] <= 1'b0; // [R17]
                        end else if (ph_hist_q[g] == RSC_PH_CLEAN) begin
                            phase_ok_q[g] <= 1'b1; // [R18]
                        end
                    end
                    if (fail_n_q[g] && !raw_ok) begin
                        fail_n_q[g] <= 1'b0; // [R04]
                        hold_cnt_q[g] <= '0;
                    end else if (!fail_n_q[g] && pfd_tick) begin
                        hold_cnt_q[g] <= hold_cnt_q[g] + 1'b1;
                        if (hold_done) begin
                            fail_n_q[g] <= raw_ok; // [R04]
                        end
                    end
                end
            end
        end
    endgenerate

    // Switch controller
    logic [RA_W-1:0] ra_cnt_q;
    wire oth = ~act_q;
    wire act_ok = fail_n_q[act_q];
    wire oth_ok = fail_n_q[oth];
    wire choice_ok = fail_n_q[choice];
    wire realign_done = pfd_tick && ra_cnt_q == REALIGN_LAST;
    always_comb begin
        st_d = st_q;
        act_d = act_q;
        unique case (st_q)
            RSC_RUN: begin
                if (manual) begin
                    if (choice != act_q) begin
                        st_d = RSC_SWITCH; // [R12] [R13]
                        act_d = choice;
                    end
                end else if (!act_ok) begin
                    if (oth_ok) begin
                        st_d = RSC_SWITCH; // [R01]
                        act_d = oth;
                    end else begin
                        st_d = RSC_HOLD; // [R10]
                    end
                end else if (choice_edge && choice != act_q && choice_ok) begin
                    st_d = RSC_SWITCH; // [R07]
                    act_d = choice;
                end
            end
            RSC_SWITCH: begin
                if (!manual && !act_ok) begin
                    st_d = RSC_HOLD; // [R05]
                end else if (realign_done) begin
                    st_d = RSC_RUN; // [R02] [R06]
                end
            end
            RSC_HOLD: begin
                if (manual) begin
                    st_d = RSC_RUN;
                    act_d = choice;
                end else if (fail_n_q == 2'b11) begin
                    st_d = RSC_RUN; // [R11]
                    act_d = choice;
                end else if (fail_n_q != 2'b00) begin
                    st_d = RSC_RUN; // [R05] [R11]
                    act_d = fail_n_q[1];
                end
            end
        endcase
    end

    wire lock_n_d = st_d == RSC_HOLD || (st_d == RSC_RUN && !fail_n_q[act_d]); // [R03]
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= RSC_RUN;
            act_q <= 1'b0;
            ra_cnt_q <= '0;
            active_ref <= 1'b0; // [R25]
            busy_n <= 1'b1;
            lock_n <= 1'b1;
        end else if (clk_en) begin
            st_q <= st_d;
            act_q <= act_d;
            ra_cnt_q <= (st_d != RSC_SWITCH || st_q != RSC_SWITCH) ? '0 :
                        pfd_tick ? ra_cnt_q + 1'b1 : ra_cnt_q;
            active_ref <= st_d == RSC_HOLD ? 1'b0 : act_d; // [R23]
            busy_n <= st_d != RSC_SWITCH; // [R02] [R23]
            lock_n <= lock_n_d;
        end
    end
    assign ref_a_fail_n = fail_n_q[0];
    assign ref_b_fail_n = fail_n_q[1];

    // Straps are sampled every enabled cycle, reset or not
    always_ff @(posedge mclk) begin
        if (clk_en) begin
            ref_freq_khz <= strap_khz(input_div_strap); // [R21]
            group_a_freq_khz <= strap_khz(group_a_div_strap); // [R22]
        end
    end

    // AXI4-Lite slave
    logic aw_got_q, w_got_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    rsc_status_t status;
    assign status = '{holdover: st_q == RSC_HOLD, busy_n: busy_n, lock_n: lock_n,
                      active: active_ref, fail_n: fail_n_q};
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
    wire wr_ctrl = awaddr_q == RSC_ADDR_CTRL;
    wire wr_ro = awaddr_q == RSC_ADDR_STATUS || awaddr_q == RSC_ADDR_STRAP;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rd_ctrl = s_axi_araddr == RSC_ADDR_CTRL;
    wire rd_stat = s_axi_araddr == RSC_ADDR_STATUS;
    wire rd_strap = s_axi_araddr == RSC_ADDR_STRAP;
    wire [31:0] rd_val = rd_ctrl ? {{(32-RSC_CTRL_W){1'b0}}, ctrl_q} :
                         rd_stat ? {{(32-RSC_STATUS_W){1'b0}}, status} :
                         rd_strap ? {6'h00, group_a_freq_khz[12:0], ref_freq_khz[12:0]} :
                         32'h0000_0000;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb0_q <= 1'b0;
            ctrl_q <= RSC_CTRL_RST;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RSC_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RSC_RESP_OKAY;
        end else if (clk_en) begin
            if (aw_take) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                if (wr_ctrl && wstrb0_q) begin
                    ctrl_q <= wdata_q[RSC_CTRL_W-1:0];
                end
                s_axi_bresp <= (wr_ctrl || wr_ro) ? RSC_RESP_OKAY : RSC_RESP_SLVERR;
                s_axi_bvalid <= 1'b1;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= (rd_ctrl || rd_stat || rd_strap) ? RSC_RESP_OKAY : RSC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    busy_switch_a: assert property ( // [R02]
        busy_n == (st_q != RSC_SWITCH)) else $error("activity output disagrees with state");
    hold_outs_a: assert property ( // [R23]
        st_q == RSC_HOLD |-> !active_ref && busy_n && lock_n) else $error("bad holdover outputs");
    switch_lock_a: assert property ( // [R03]
        st_q == RSC_SWITCH |-> !lock_n) else $error("lock lost during switchover");
    fail_hold_a: assert property ( // [R04]
        $rose(ref_a_fail_n) |-> $past(hold_cnt_q[0]) == RSC_HOLD_LAST && $past(pfd_tick))
        else $error("failure flag released early");
    manual_follow_a: assert property ( // [R12]
        clk_en && manual && st_q == RSC_RUN && act_q != choice
        |=> st_q == RSC_SWITCH && active_ref == $past(choice)) else $error("manual choice ignored");
    auto_fail_a: assert property ( // [R01]
        clk_en && !manual && st_q == RSC_RUN && !act_ok && oth_ok
        |=> st_q == RSC_SWITCH && act_q != $past(act_q)) else $error("no failover");
    both_bad_a: assert property ( // [R10]
        clk_en && !manual && st_q == RSC_RUN && fail_n_q == 2'b00 |=> st_q == RSC_HOLD)
        else $error("no holdover with both invalid");
    phase_disq_a: assert property ( // [R17]
        $fell(phase_ok_q[0]) |-> $past(ph_bad[0]) > 4'(RSC_PH_BAD_MAX))
        else $error("phase disqualified too early");
    phase_qual_a: assert property ( // [R18]
        $rose(phase_ok_q[0]) |-> $past(ph_hist_q[0]) == RSC_PH_CLEAN)
        else $error("phase qualified too early");
    freq_hyst_a: assert property ( // [R20]
        $rose(freq_ok_q[1]) |-> $past(ref_in[1].freq_dev) <= RSC_FQ_QUAL_TENTHS)
        else $error("frequency qualified outside window");
    stay_sec_a: assert property ( // [R06]
        clk_en && !manual && st_q == RSC_RUN && act_ok && !choice_edge |=> act_q == $past(act_q))
        else $error("left a valid reference");

    auto_switch_c: cover property (!manual && st_q == RSC_SWITCH ##1 st_q == RSC_RUN);
    hold_exit_c: cover property (st_q == RSC_HOLD ##1 st_q == RSC_RUN);
    user_switch_c: cover property (!manual && choice_edge && st_d == RSC_SWITCH);
endmodule

// file: tb/rsc_ref_model.sv
`timescale 1ns/1ps
module rsc_ref_model
    import rsc_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [1:0] amp_good,
    input wire logic [1:0] phase_bad,
    input wire logic [7:0] dev_a,
    input wire logic [7:0] dev_b,
    output logic pfd_tick,
    output rsc_ref_in_t [1:0] ref_in
);
    logic [1:0] div_q;
    // Two ticks in every three cycles stand in for a 66.67 MHz detector at 100 MHz
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            div_q <= 2'h0;
        else if (div_q == 2'h2)
            div_q <= 2'h0;
        else
            div_q <= div_q + 2'h1;
    end
    assign pfd_tick = (div_q != 2'h2);
    // Each source reports its three qualification inputs independently
    assign ref_in[0] = '{amp_ok: amp_good[0], phase_err: phase_bad[0], freq_dev: dev_a};
    assign ref_in[1] = '{amp_ok: amp_good[1], phase_err: phase_bad[1], freq_dev: dev_b};
endmodule

// file: tb/tb_redundant_ref_switch_ctrl.sv
`timescale 1ns/1ps
module tb_redundant_ref_switch_ctrl;
    import rsc_pkg::*;
    localparam int FA = 0;
    localparam int FB = 1;
    localparam int ACT = 2;
    localparam int BSY = 3;
    localparam int LCK = 4;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] amp_good = 2'h3;
    logic [1:0] phase_bad = 2'h0;
    logic [7:0] dev_a = 8'h00;
    logic [7:0] dev_b = 8'h00;
    logic choice = 1'b0;
    logic manual = 1'b0;
    logic bypass = 1'b0;
    logic en = 1'b1;
    logic [1:0] div_s = 2'h0;
    logic [1:0] grp_s = 2'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pfd_tick;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    rsc_ref_in_t [1:0] ref_in;
    logic ref_a_fail_n, ref_b_fail_n, active_ref, busy_n, lock_n;
    logic [RSC_KHZ_W-1:0] ref_freq_khz, group_a_freq_khz;
    logic [RSC_KHZ_W-1:0] f_tab [4] = '{RSC_F_GND, RSC_F_VCC, RSC_F_OPEN, RSC_F_RES};
    int n_errors = 0;
    int samples_checked = 0;
    int k;

    initial begin
        forever #5 mclk = ~mclk;
    end

    rsc_ref_model u_src (.mclk(mclk), .sys_rst(sys_rst), .amp_good(amp_good),
        .phase_bad(phase_bad), .dev_a(dev_a), .dev_b(dev_b), .pfd_tick(pfd_tick),
        .ref_in(ref_in));

    rsc_switch_ctrl #(.REALIGN_PFD(4), .ADDR_W(8)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .clk_en(en), .pfd_tick(pfd_tick), .ref_in(ref_in), .ref_choice_pin(choice),
        .switch_policy_pin(manual), .bypass_pin(bypass), .input_div_strap(div_s),
        .group_a_div_strap(grp_s), .ref_a_fail_n(ref_a_fail_n), .ref_b_fail_n(ref_b_fail_n),
        .active_ref(active_ref), .busy_n(busy_n), .lock_n(lock_n),
        .ref_freq_khz(ref_freq_khz), .group_a_freq_khz(group_a_freq_khz),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    task automatic end_of_test;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic err(input string m);
        n_errors++;
        $display("mismatch at %0t: %s", $time, m);
    endtask

    function automatic logic obs(input int i);
        case (i)
            FA: return ref_a_fail_n;
            FB: return ref_b_fail_n;
            ACT: return active_ref;
            BSY: return busy_n;
            default: return lock_n;
        endcase
    endfunction

    task automatic check(input int i, input logic v);
        samples_checked++;
        if (obs(i) !== v) err($sformatf("output %0d is %b, expected %b", i, obs(i), v));
    endtask

    // Bounded wait; running out of cycles ends the run at once
    task automatic wait_for(input int i, input logic v, input int n);
        int c;
        c = 0;
        do begin
            @(negedge mclk);
            c++;
        end while (obs(i) !== v && c < n);
        check(i, v);
        if (obs(i) !== v) end_of_test();
    endtask

    task automatic stay(input int i, input logic v, input int n);
        bit bad;
        bad = 0;
        repeat (n) begin
            @(negedge mclk);
            if (obs(i) !== v) bad = 1;
        end
        samples_checked++;
        if (bad) err($sformatf("output %0d left level %b", i, v));
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        bit got;
        got = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 50 && !got; i++) begin
            @(posedge mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                got = 1;
                samples_checked++;
                if (bresp !== er) err("write response");
            end
        end
        bready <= 1'b0;
        if (!got) begin
            err("write timeout");
            end_of_test();
        end
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int i;
        bit got;
        got = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 50 && !got; i++) begin
            @(posedge mclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                got = 1;
                samples_checked++;
                if (rdata !== ed || rresp !== er) err($sformatf("read %h got %h", a, rdata));
            end
        end
        rready <= 1'b0;
        if (!got) begin
            err("read timeout");
            end_of_test();
        end
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        for (k = 0; k < 5; k++) check(k, k != ACT);
        @(posedge mclk);
        sys_rst <= 1'b0;
        for (k = 0; k < 4; k++) begin
            @(posedge mclk);
            div_s <= 2'(k);
            grp_s <= 2'(3 - k);
            repeat (3) @(negedge mclk);
            samples_checked++;
            if (ref_freq_khz !== f_tab[k]) err("input divider frequency");
            if (group_a_freq_khz !== f_tab[3 - k]) err("group A frequency");
        end
        // Frequency is unqualified at release, so both flags drop and hold 128 ticks first
        wait_for(LCK, 1'b0, 300);
        check(ACT, 1'b0);
        // Idle reference: phase errors ignored, 4.0 % deviation still inside hysteresis
        @(posedge mclk);
        phase_bad[1] <= 1'b1;
        dev_b <= 8'h28;
        stay(FB, 1'b1, 100);
        @(posedge mclk);
        phase_bad[1] <= 1'b0;
        amp_good[0] <= 1'b0;
        wait_for(FA, 1'b0, 30);
        wait_for(BSY, 1'b0, 10);
        check(LCK, 1'b0);
        wait_for(ACT, 1'b1, 10);
        wait_for(BSY, 1'b1, 40);
        @(posedge mclk);
        amp_good[0] <= 1'b1;
        stay(FA, 1'b0, 100);
        wait_for(FA, 1'b1, 300);
        check(ACT, 1'b1);
        // Same-as-active choice edge must not switch; the edge back to A must
        @(posedge mclk);
        choice <= 1'b1;
        stay(ACT, 1'b1, 6);
        @(posedge mclk);
        choice <= 1'b0;
        wait_for(ACT, 1'b0, 20);
        wait_for(BSY, 1'b1, 40);
        @(posedge mclk);
        dev_b <= 8'h51;
        wait_for(FB, 1'b0, 20);
        @(posedge mclk);
        phase_bad[0] <= 1'b1;
        wait_for(FA, 1'b0, 40);
        wait_for(ACT, 1'b0, 20);
        check(BSY, 1'b1);
        check(LCK, 1'b1);
        axi_read(RSC_ADDR_STATUS, 32'h38, RSC_RESP_OKAY);
        @(posedge mclk);
        phase_bad[0] <= 1'b0;
        amp_good[0] <= 1'b0;
        dev_b <= 8'h00;
        wait_for(FB, 1'b1, 400);
        wait_for(ACT, 1'b1, 20);
        @(posedge mclk);
        bypass <= 1'b1;
        wait_for(ACT, 1'b0, 20);
        check(FA, 1'b0);
        @(posedge mclk);
        bypass <= 1'b0;
        manual <= 1'b1;
        choice <= 1'b1;
        wait_for(ACT, 1'b1, 20);
        axi_write(RSC_ADDR_CTRL, 32'h6, RSC_RESP_OKAY);
        axi_read(RSC_ADDR_CTRL, 32'h6, RSC_RESP_OKAY);
        wait_for(ACT, 1'b0, 20);
        // Clock enable low must freeze the amplitude filter and the flags
        @(posedge mclk);
        en <= 1'b0;
        amp_good[1] <= 1'b0;
        stay(FB, 1'b1, 20);
        @(posedge mclk);
        en <= 1'b1;
        wait_for(FB, 1'b0, 20);
        axi_write(8'h0C, 32'h1, RSC_RESP_SLVERR);
        axi_read(8'h0C, 32'h0, RSC_RESP_SLVERR);
        axi_read(RSC_ADDR_STRAP, {6'h0, RSC_F_GND[12:0], RSC_F_RES[12:0]}, RSC_RESP_OKAY);
        // Reset in mid-run drops everything but the strap frequencies back to its idle state
        @(posedge mclk);
        sys_rst <= 1'b1;
        @(negedge mclk);
        for (k = 0; k < 5; k++) check(k, k != ACT);
        @(posedge mclk);
        sys_rst <= 1'b0;
        axi_read(RSC_ADDR_CTRL, 32'h0, RSC_RESP_OKAY);
        end_of_test();
    end
endmodule
